// ---- verilog/lsd_consts.svh ----
// Purpose: Constants for the left shift decode and execute block
// Assumes: 16-bit and 32-bit instruction words, 32-bit data path
// Notes: Widths, fixed values and opcode patterns only
`ifndef LSD_CONSTS_SVH
`define LSD_CONSTS_SVH

`define LSD_DATA_W 32
`define LSD_CNT_LO_W 8
`define LSD_AMT_W 5
`define LSD_IDX_W 4
`define LSD_ZERO_AMT 5'h00
`define LSD_ZERO_WORD 32'h0000_0000
`define LSD_WORD_BITS 9'h020
// 16-bit immediate form: bits 15..11 equal 00000
`define LSD_N16_IMM_OP 5'h00
// 16-bit register form: bits 15..6 equal 0100000010
`define LSD_N16_REG_OP 10'h102
// 32-bit immediate form: bits 31..16 equal 11101010010s1111
`define LSD_W_IMM_HI 11'h752
`define LSD_W_IMM_LO 4'hf
// 32-bit register form: bits 31..21 = 11111010000, bits 15..12 = 1111, bits 7..4 = 0000
`define LSD_W_REG_HI 11'h7d0
`define LSD_W_REG_MID 4'hf
`define LSD_W_REG_TY 4'h0
`define LSD_SHIFT_TYPE_LEFT 2'h0

`endif

// ---- verilog/lsd_pkg.sv ----
// Purpose: Types for the left shift decode and execute block
// Assumes: Constants header included here
// Notes: Types only
`include "lsd_consts.svh"

package lsd_pkg;

    typedef enum logic [2:0] {
        LSD_FORM_NONE,
        LSD_FORM_N16_IMM,
        LSD_FORM_N16_REG,
        LSD_FORM_W_IMM,
        LSD_FORM_W_REG
    } lsd_form_t;

    typedef struct packed {
        logic valid;
        logic is_wide;
        logic [31:0] word;
        logic in_conditional_block;
    } lsd_instr_t;

    typedef struct packed {
        logic [`LSD_IDX_W-1:0] dest_index;
        logic [`LSD_IDX_W-1:0] source_index;
        logic [`LSD_IDX_W-1:0] shift_count_index;
        logic [`LSD_AMT_W-1:0] imm_amount;
        logic by_register;
        logic set_flags;
        logic hit;
        logic undefined;
    } lsd_decode_t;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } lsd_flags_t;

endpackage

// ---- verilog/lsd_shifter.sv ----
// Purpose: Logical left shift with carry out
// Assumes: Amount up to 255, carry in passes through for zero amount
// Notes: Purely combinational
`include "lsd_consts.svh"

module lsd_shifter (
    input wire logic [`LSD_DATA_W-1:0] operand, // Value to shift
    input wire logic [`LSD_CNT_LO_W-1:0] amount, // Shift amount
    input wire logic carry_in, // Current carry flag
    output logic [`LSD_DATA_W-1:0] result, // Shifted value
    output logic carry_out // Last bit shifted out
);

    logic [`LSD_DATA_W:0] wide;

    always_comb
    begin
        wide = {1'b0, operand};
        result = `LSD_ZERO_WORD;
        carry_out = carry_in;
        if (amount == 8'h00)
        begin
            result = operand;
        end
        else if ({1'b0, amount} < `LSD_WORD_BITS)
        begin
            wide = {1'b0, operand} << amount;
            result = wide[`LSD_DATA_W-1:0];
            carry_out = wide[`LSD_DATA_W];
        end
        else if ({1'b0, amount} == `LSD_WORD_BITS)
        begin
            carry_out = operand[0];
        end
        else
        begin
            carry_out = 1'b0;
        end
    end

endmodule

// ---- verilog/lsd_decode_exec.sv ----
// Purpose: Decode and execute the logical left shift instruction family
// Assumes: Register file read ports answer combinationally by index
// Notes: One instruction per cycle, results registered one cycle later
`include "lsd_consts.svh"

module lsd_decode_exec (
    input wire logic clk, // Core clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic main_ext, // Main architecture extension present
    input wire lsd_pkg::lsd_instr_t instr, // Instruction from fetch
    input wire logic [`LSD_DATA_W-1:0] source_data, // Value of source register
    input wire logic [`LSD_DATA_W-1:0] count_data, // Value of shift count register
    input wire lsd_pkg::lsd_flags_t flags_in, // Current condition flags
    output lsd_pkg::lsd_decode_t dec, // Decoded fields, drives read ports
    output logic wr_en, // Register write strobe
    output logic [`LSD_IDX_W-1:0] wr_index, // Destination register
    output logic [`LSD_DATA_W-1:0] wr_data, // Result value
    output logic flags_we, // Flag write strobe
    output lsd_pkg::lsd_flags_t flags_out, // New condition flags
    output logic undef_fault // Undefined instruction fault pulse
);

    // ****************************************
    // Decode
    // ****************************************
    lsd_pkg::lsd_form_t form;
    logic [`LSD_CNT_LO_W-1:0] amount;
    logic [`LSD_DATA_W-1:0] shifted;
    logic carry_new;

    function automatic logic [`LSD_IDX_W-1:0] low_reg(input logic [2:0] f);
        low_reg = {1'b0, f};
    endfunction

    always_comb
    begin
        form = lsd_pkg::LSD_FORM_NONE;
        dec = '0;
        if (instr.valid && !instr.is_wide)
        begin
            if (instr.word[15:11] == `LSD_N16_IMM_OP
                && instr.word[10:6] != `LSD_ZERO_AMT)
            begin
                form = lsd_pkg::LSD_FORM_N16_IMM;
                dec.source_index = low_reg(instr.word[5:3]);
                dec.dest_index = low_reg(instr.word[2:0]);
                dec.imm_amount = instr.word[10:6];
            end
            else if (instr.word[15:6] == `LSD_N16_REG_OP)
            begin
                form = lsd_pkg::LSD_FORM_N16_REG;
                dec.source_index = low_reg(instr.word[2:0]);
                dec.dest_index = low_reg(instr.word[2:0]);
                dec.shift_count_index = low_reg(instr.word[5:3]);
                dec.by_register = 1'b1;
            end
            if (form != lsd_pkg::LSD_FORM_NONE)
            begin
                dec.set_flags = !instr.in_conditional_block;
            end
        end
        else if (instr.valid)
        begin
            if (instr.word[31:21] == `LSD_W_IMM_HI && instr.word[19:16] == `LSD_W_IMM_LO
                && instr.word[5:4] == `LSD_SHIFT_TYPE_LEFT)
            begin
                form = lsd_pkg::LSD_FORM_W_IMM;
                dec.imm_amount = {instr.word[14:12], instr.word[7:6]};
                dec.dest_index = instr.word[11:8];
                dec.source_index = instr.word[3:0];
                dec.set_flags = instr.word[20];
            end
            else if (instr.word[31:21] == `LSD_W_REG_HI
                && instr.word[22:21] == `LSD_SHIFT_TYPE_LEFT
                && instr.word[15:12] == `LSD_W_REG_MID
                && instr.word[7:4] == `LSD_W_REG_TY)
            begin
                form = lsd_pkg::LSD_FORM_W_REG;
                dec.source_index = instr.word[19:16];
                dec.dest_index = instr.word[11:8];
                dec.shift_count_index = instr.word[3:0];
                dec.set_flags = instr.word[20];
                dec.by_register = 1'b1;
            end
        end
        dec.hit = form != lsd_pkg::LSD_FORM_NONE;
        // Only the flagged short forms belong to the baseline
        dec.undefined = dec.hit && !main_ext
            && (instr.is_wide || !dec.set_flags);
    end

    // ****************************************
    // Execute
    // ****************************************
    always_comb
    begin
        if (dec.by_register)
        begin
            amount = count_data[`LSD_CNT_LO_W-1:0];
        end
        else
        begin
            amount = {3'h0, dec.imm_amount};
        end
    end

    // Same datapath as the shifted register move
    lsd_shifter lsd_shifter_inst (
        .operand(source_data),
        .amount(amount),
        .carry_in(flags_in.c),
        .result(shifted),
        .carry_out(carry_new)
    );

    // ****************************************
    // Result registers
    // ****************************************
    logic wr_en_next;
    logic [`LSD_IDX_W-1:0] wr_index_next;
    logic [`LSD_DATA_W-1:0] wr_data_next;
    logic flags_we_next;
    lsd_pkg::lsd_flags_t flags_out_next;
    logic undef_next;

    always_comb
    begin
        wr_en_next = dec.hit && !dec.undefined;
        wr_index_next = wr_index;
        wr_data_next = wr_data;
        flags_we_next = 1'b0;
        flags_out_next = flags_out;
        undef_next = dec.undefined;
        if (wr_en_next)
        begin
            wr_index_next = dec.dest_index;
            wr_data_next = shifted;
            flags_we_next = dec.set_flags;
            if (dec.set_flags)
            begin
                flags_out_next.n = shifted[`LSD_DATA_W-1];
                flags_out_next.z = shifted == `LSD_ZERO_WORD;
                flags_out_next.c = carry_new;
                flags_out_next.v = flags_in.v;
            end
            else
            begin
                flags_out_next = flags_in;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_en <= 1'b0;
            wr_index <= '0;
            wr_data <= `LSD_ZERO_WORD;
            flags_we <= 1'b0;
            flags_out <= '0;
            undef_fault <= 1'b0;
        end
        else
        begin
            wr_en <= wr_en_next;
            wr_index <= wr_index_next;
            wr_data <= wr_data_next;
            flags_we <= flags_we_next;
            flags_out <= flags_out_next;
            undef_fault <= undef_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_ZERO_LOW: assert property (@(posedge clk) disable iff (!resetn)
        (wr_en_next && amount != 8'h00 && amount < 8'h20) |=> wr_data[0] == 1'b0)
        else $error("low bit not zero after shift");
    AST_BIG_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        (wr_en_next && amount >= 8'h20) |=> wr_data == 32'h0000_0000)
        else $error("large shift not zero");
    AST_COUNT_LOW: assert property (@(posedge clk) disable iff (!resetn)
        (wr_en_next && dec.by_register) |=> wr_data == $past(source_data) << $past(count_data[7:0]))
        else $error("count not from low byte");
    AST_IMM_SHIFT: assert property (@(posedge clk) disable iff (!resetn)
        (wr_en_next && !dec.by_register) |=> wr_data == $past(source_data) << $past(dec.imm_amount))
        else $error("immediate shift wrong");
    AST_NOFLAG: assert property (@(posedge clk) disable iff (!resetn)
        (wr_en_next && !dec.set_flags) |=> !flags_we)
        else $error("flags written by unflagged form");
    AST_ZFLAG: assert property (@(posedge clk) disable iff (!resetn)
        flags_we |-> flags_out.z == (wr_data == 32'h0000_0000))
        else $error("zero flag mismatch");
    AST_ITBLOCK: assert property (@(posedge clk) disable iff (!resetn)
        (dec.hit && !instr.is_wide) |-> dec.set_flags == !instr.in_conditional_block)
        else $error("short form flag choice wrong");
    AST_UNDEF: assert property (@(posedge clk) disable iff (!resetn)
        (dec.hit && instr.is_wide && !main_ext) |=> undef_fault && !wr_en)
        else $error("missing undefined fault");
    AST_N16_AMT: assert property (@(posedge clk) disable iff (!resetn)
        (instr.valid && !instr.is_wide && instr.word[15:6] == 10'h000) |-> !dec.hit)
        else $error("zero amount decoded as shift");

    // ****************************************
    // Checks on fields, faults and flags
    // ****************************************
    // Field extraction
    AST_N16_IDX: assert property (@(posedge clk) disable iff (!resetn)
        form == lsd_pkg::LSD_FORM_N16_IMM |-> dec.source_index == {1'b0, instr.word[5:3]}
            && dec.dest_index == {1'b0, instr.word[2:0]})
        else $error("short immediate fields wrong");
    AST_N16_REG_IDX: assert property (@(posedge clk) disable iff (!resetn)
        form == lsd_pkg::LSD_FORM_N16_REG |-> dec.source_index == dec.dest_index
            && dec.shift_count_index == {1'b0, instr.word[5:3]})
        else $error("short register fields wrong");
    AST_W_AMT: assert property (@(posedge clk) disable iff (!resetn)
        form == lsd_pkg::LSD_FORM_W_IMM
            |-> dec.imm_amount == {instr.word[14:12], instr.word[7:6]})
        else $error("wide amount wrong");
    AST_W_IMM_IDX: assert property (@(posedge clk) disable iff (!resetn)
        form == lsd_pkg::LSD_FORM_W_IMM |-> dec.dest_index == instr.word[11:8]
            && dec.source_index == instr.word[3:0] && instr.word[5:4] == 2'h0)
        else $error("wide immediate fields wrong");
    AST_W_REG_IDX: assert property (@(posedge clk) disable iff (!resetn)
        form == lsd_pkg::LSD_FORM_W_REG |-> dec.source_index == instr.word[19:16]
            && dec.shift_count_index == instr.word[3:0] && dec.dest_index == instr.word[11:8])
        else $error("wide register fields wrong");
    AST_WIDE_FLAG: assert property (@(posedge clk) disable iff (!resetn)
        (dec.hit && instr.is_wide) |-> dec.set_flags == instr.word[20])
        else $error("wide flag bit ignored");
    AST_N16_NONZERO: assert property (@(posedge clk) disable iff (!resetn)
        form == lsd_pkg::LSD_FORM_N16_IMM |-> dec.imm_amount != 5'h00)
        else $error("short immediate with zero amount");

    // Faults and baseline forms
    AST_BASELINE: assert property (@(posedge clk) disable iff (!resetn)
        (dec.hit && !instr.is_wide && !instr.in_conditional_block) |-> !dec.undefined)
        else $error("baseline short form refused");
    AST_EXT_DEFINED: assert property (@(posedge clk) disable iff (!resetn)
        main_ext |-> !dec.undefined)
        else $error("fault with extension present");
    AST_UNDEF_SHORT: assert property (@(posedge clk) disable iff (!resetn)
        (dec.hit && !instr.is_wide && instr.in_conditional_block && !main_ext)
            |=> undef_fault && !wr_en)
        else $error("unflagged short form not refused");
    AST_FAULT_ONLY: assert property (@(posedge clk) disable iff (!resetn)
        undef_fault |-> !wr_en && !flags_we)
        else $error("write beside fault");
    AST_WRITE_DEST: assert property (@(posedge clk) disable iff (!resetn)
        wr_en_next |=> wr_en && wr_index == $past(dec.dest_index))
        else $error("write index wrong");
    AST_IDLE: assert property (@(posedge clk) disable iff (!resetn)
        !dec.hit |=> !wr_en && !undef_fault && !flags_we)
        else $error("activity without a decoded shift");
    AST_HOLD_DATA: assert property (@(posedge clk) disable iff (!resetn)
        !wr_en_next |=> $stable(wr_data) && $stable(wr_index))
        else $error("result changed without a write");

    // Flags and amount selection
    AST_NFLAG: assert property (@(posedge clk) disable iff (!resetn)
        flags_we |-> flags_out.n == wr_data[`LSD_DATA_W-1])
        else $error("negative flag mismatch");
    AST_VFLAG: assert property (@(posedge clk) disable iff (!resetn)
        flags_we |-> flags_out.v == $past(flags_in.v))
        else $error("overflow flag changed");
    AST_KEEP_FLAGS: assert property (@(posedge clk) disable iff (!resetn)
        (wr_en_next && !dec.set_flags) |=> flags_out == $past(flags_in))
        else $error("unflagged form altered flags");
    AST_CARRY_BIG: assert property (@(posedge clk) disable iff (!resetn)
        (wr_en_next && dec.set_flags && amount > 8'h20) |=> !flags_out.c)
        else $error("carry not cleared beyond word");
    AST_CARRY_32: assert property (@(posedge clk) disable iff (!resetn)
        (wr_en_next && dec.set_flags && amount == 8'h20) |=> flags_out.c == $past(source_data[0]))
        else $error("carry not bit zero at full word");
    AST_CARRY_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        (wr_en_next && dec.set_flags && amount == 8'h00) |=> flags_out.c == $past(flags_in.c))
        else $error("carry changed by zero count");
    AST_COUNT_SEL: assert property (@(posedge clk) disable iff (!resetn)
        dec.by_register |-> amount == count_data[`LSD_CNT_LO_W-1:0])
        else $error("count not taken from register");
    AST_REG_SHORT: assert property (@(posedge clk) disable iff (!resetn)
        form == lsd_pkg::LSD_FORM_N16_REG |-> dec.by_register)
        else $error("short register form not by register");
    AST_IMM_FORMS: assert property (@(posedge clk) disable iff (!resetn)
        (form == lsd_pkg::LSD_FORM_N16_IMM || form == lsd_pkg::LSD_FORM_W_IMM)
            |-> !dec.by_register && amount[7:5] == 3'h0)
        else $error("immediate form amount wrong");

    COV_SHORT_IMM: cover property (@(posedge clk) form == lsd_pkg::LSD_FORM_N16_IMM && wr_en_next);
    COV_WIDE_REG: cover property (@(posedge clk) form == lsd_pkg::LSD_FORM_W_REG && wr_en_next);
    COV_BIG: cover property (@(posedge clk) wr_en_next && amount > 8'h20);
    COV_UNDEF: cover property (@(posedge clk) dec.undefined);
    COV_KEEP_FLAGS: cover property (@(posedge clk) wr_en_next && !dec.set_flags);

endmodule

// ---- testbench/lsd_regfile_model.sv ----
// Purpose: Register file on the far side of the shift block
// Assumes: Read ports answer combinationally by decoded index
// Notes: Bench preloads registers, design results are written back
`include "lsd_consts.svh"

module lsd_regfile_model (
    input wire logic clk, // Core clock
    input wire lsd_pkg::lsd_decode_t dec, // Decoded read indices
    input wire logic wr_en, // Design write strobe
    input wire logic [`LSD_IDX_W-1:0] wr_index, // Design write index
    input wire logic [`LSD_DATA_W-1:0] wr_data, // Design write value
    input wire logic set_en, // Bench preload strobe
    input wire logic [`LSD_IDX_W-1:0] set_index, // Preload index
    input wire logic [`LSD_DATA_W-1:0] set_value, // Preload value
    output logic [`LSD_DATA_W-1:0] source_data, // Source read
    output logic [`LSD_DATA_W-1:0] count_data // Count read
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [`LSD_DATA_W-1:0] regs [16];
    always_ff @(posedge clk)
    begin
        if (set_en)
            regs[set_index] <= set_value;
        else if (wr_en)
            regs[wr_index] <= wr_data;
    end
    assign source_data = regs[dec.source_index];
    assign count_data = regs[dec.shift_count_index];
endmodule

// ---- testbench/tb_left_shift_instruction_decode.sv ----
// Purpose: Self-checking bench for the left shift decode block
// Assumes: One-cycle answer, flags in held at n=0 z=0 c=1 v=1
// Notes: Each scenario preloads registers, issues words, checks results
`include "lsd_consts.svh"

module tb_left_shift_instruction_decode;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, main_ext, wr_en, flags_we, undef_fault, set_en;
    lsd_pkg::lsd_instr_t instr;
    lsd_pkg::lsd_flags_t flags_in, flags_out;
    lsd_pkg::lsd_decode_t dec;
    logic [31:0] source_data, count_data, wr_data, set_value;
    logic [3:0] wr_index, set_index;
    int err_total = 0;
    int checked = 0;

    lsd_decode_exec lsd_decode_exec_inst (.clk(clk), .resetn(resetn), .main_ext(main_ext),
        .instr(instr), .source_data(source_data), .count_data(count_data),
        .flags_in(flags_in), .dec(dec), .wr_en(wr_en), .wr_index(wr_index),
        .wr_data(wr_data), .flags_we(flags_we), .flags_out(flags_out),
        .undef_fault(undef_fault));
    lsd_regfile_model lsd_regfile_model_inst (.clk(clk), .dec(dec), .wr_en(wr_en),
        .wr_index(wr_index), .wr_data(wr_data), .set_en(set_en), .set_index(set_index),
        .set_value(set_value), .source_data(source_data), .count_data(count_data));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic set_reg(input logic [3:0] idx, input logic [31:0] val);
        @(posedge clk);
        #1 set_en = 1'b1;
        set_index = idx;
        set_value = val;
        @(posedge clk);
        #1 set_en = 1'b0;
    endtask

    // Presents one word for one cycle, returns after the answering edge
    task automatic issue(input logic wide, input logic [31:0] word, input logic inblk);
        @(posedge clk);
        #1 instr = '{valid: 1'b1, is_wide: wide, word: word, in_conditional_block: inblk};
        @(posedge clk);
        #1 instr.valid = 1'b0;
    endtask

    task automatic do_op(input logic wide, input logic [31:0] word, input logic inblk,
        input logic [3:0] dest, input logic [31:0] val, input logic [7:0] amt,
        input logic flagged);
        logic [32:0] t;
        logic c;
        t = {1'b0, val} << amt;
        c = (amt == 8'h00) ? flags_in.c : (amt > 8'h20) ? 1'b0 : t[32];
        if (amt > 8'h20)
            t = 33'h0;
        issue(wide, word, inblk);
        chk_bit(wr_en, 1'b1);
        chk_bit(undef_fault, 1'b0);
        chk_word({28'h0, wr_index}, {28'h0, dest});
        chk_word(wr_data, t[31:0]);
        chk_bit(flags_we, flagged);
        if (flagged)
            chk_word({28'h0, flags_out}, {28'h0, t[31:0] == 32'h0 ? 2'h1 : {t[31], 1'b0},
                c, flags_in.v});
        else
            chk_word({28'h0, flags_out}, {28'h0, flags_in});
    endtask

    task automatic no_op(input logic wide, input logic [31:0] word, input logic inblk,
        input logic undef);
        issue(wide, word, inblk);
        chk_bit(wr_en, 1'b0);
        chk_bit(undef_fault, undef);
    endtask

    task automatic t_short_imm;
        set_reg(4'h3, 32'hc000_0003);
        do_op(1'b0, {16'h0, 5'h00, 5'h01, 3'h3, 3'h5}, 1'b0, 4'h5, 32'hc000_0003, 8'h01,
            1'b1);
        do_op(1'b0, {16'h0, 5'h00, 5'h1f, 3'h3, 3'h0}, 1'b1, 4'h0, 32'hc000_0003, 8'h1f,
            1'b0);
        no_op(1'b0, {16'h0, 5'h00, 5'h00, 3'h3, 3'h1}, 1'b0, 1'b0);
        $display("short immediate done");
    endtask

    task automatic t_short_reg;
        logic [7:0] cnt [5] = '{8'h04, 8'h20, 8'h21, 8'h00, 8'h1f};
        for (int i = 0; i < 5; i++)
        begin
            set_reg(4'h2, 32'h8765_4321);
            set_reg(4'h5, {24'hffff01, cnt[i]});
            do_op(1'b0, {16'h0, 10'h102, 3'h5, 3'h2}, i == 4, 4'h2, 32'h8765_4321, cnt[i],
                i != 4);
        end
        $display("short register done");
    endtask

    task automatic t_wide;
        set_reg(4'hc, 32'h0001_8001);
        set_reg(4'h8, 32'hff00_0005);
        for (int s = 0; s < 2; s++)
        begin
            do_op(1'b1, {11'h752, s[0], 4'hf, 1'b0, 3'h4, 4'h9, 2'h1, 2'h0, 4'hc}, 1'b0,
                4'h9, 32'h0001_8001, 8'h11, s[0]);
            do_op(1'b1, {11'h7d0, s[0], 4'hc, 4'hf, 4'he, 4'h0, 4'h8}, 1'b1, 4'he,
                32'h0001_8001, 8'h05, s[0]);
        end
        $display("wide forms done");
    endtask

    task automatic t_no_ext;
        main_ext = 1'b0;
        set_reg(4'h1, 32'h0000_00f0);
        no_op(1'b1, {11'h752, 1'b1, 4'hf, 1'b0, 3'h1, 4'h2, 2'h0, 2'h0, 4'h1}, 1'b0,
            1'b1);
        no_op(1'b0, {16'h0, 10'h102, 3'h1, 3'h1}, 1'b1, 1'b1);
        do_op(1'b0, {16'h0, 5'h00, 5'h04, 3'h1, 3'h6}, 1'b0, 4'h6, 32'h0000_00f0, 8'h04,
            1'b1);
        main_ext = 1'b1;
        $display("baseline only done");
    endtask

    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        resetn = 1'b0;
        main_ext = 1'b1;
        instr = '0;
        flags_in = '{n: 1'b0, z: 1'b0, c: 1'b1, v: 1'b1};
        set_en = 1'b0;
        set_index = 4'h0;
        set_value = 32'h0;
        repeat (2) @(posedge clk);
        #1 resetn = 1'b1;
        t_short_imm();
        t_short_reg();
        t_wide();
        t_no_ext();
        finish_test();
    end

    initial
    begin
        #20000;
        err_total++;
        finish_test();
    end
endmodule
